// ===== src/apm_core.sv
// alarm precedence, masking, indicator latch and output restore
// assumes synchronous pins, an outside store for power-cycle state
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// button hold timer
// ****************************************
module apm_hold
	import apm_pkg::*;
#(
	parameter int unsigned N = 16
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic btn,
	output logic      long_p,
	output logic      short_p
);
	logic [HOLD_W-1:0] cnt_q;
	logic              done_q;
	wire logic         last_w = (cnt_q == HOLD_W'(N - 1));

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_q   <= '0;
			done_q  <= 1'b0;
			long_p  <= 1'b0;
			short_p <= 1'b0;
		end else begin
			long_p  <= btn & ~done_q & last_w;
			short_p <= ~btn & ~done_q & (cnt_q != '0);
			done_q  <= btn & (done_q | last_w);
			cnt_q   <= (btn & ~done_q & ~last_w) ? cnt_q + 1'b1 :
				(btn ? cnt_q : '0);
		end
	end
endmodule

// ****************************************
// top
// ****************************************
module apm_core
	import apm_pkg::*;
#(
	parameter int unsigned OUT_HOLD = OUT_HOLD_CYC,
	parameter int unsigned ENC_HOLD = ENC_HOLD_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [9:0]  alarm_src,
	input  wire logic        chk_fail,
	input  wire logic        nv_out_prev,
	input  wire logic        nv_out_rst,
	input  wire logic        nv_aux_rst,
	input  wire logic        btn_out,
	input  wire logic        btn_aux,
	input  wire logic        btn_enc,
	output logic             out_en_q,
	output logic             aux_en_q,
	output logic             alarm_led_q,
	output logic [3:0]       disp_msg_q,
	output logic             disp_blink_q,
	output logic             out_rst,
	output logic             aux_rst
);
	logic       wait_q;
	logic [8:0] mask_q;
	logic [7:0] latch_q;
	apm_cfg_t   cfg_q;
	logic [9:0] pend_q;
	logic       boot_q;
	logic       ff_q;
	logic       trip_q;
	logic       pre_q;
	logic       lhit_q;
	logic       oset_q;
	logic       aset_q;
	logic [3:0] top_idx;
	logic [3:0] disp_d;
	logic       out_long;
	logic       out_short;
	logic       aux_long;
	logic       aux_short;
	logic       enc_long;

	assign avs_waitrequest = wait_q;
	assign out_rst = cfg_q.out_rst;
	assign aux_rst = cfg_q.aux_rst;

	// ****************************************
	// register bus
	// ****************************************
	wire logic        req_w = avs_read | avs_write;
	wire logic        wr_w  = avs_write & ~wait_q;
	wire logic [15:0] bm_w  = {{8{avs_byteenable[1]}},
		{8{avs_byteenable[0]}}};
	wire logic [8:0]  mwm_w = MASK_WM & bm_w[8:0];
	wire logic [7:0]  lwm_w = LATCH_WM & bm_w[7:0];
	wire logic        ctl_w = wr_w & (avs_address == REG_CTRL)
		& avs_byteenable[0];
	wire logic        wmsk_w = wr_w & (avs_address == REG_MASK);
	wire logic        wlat_w = wr_w & (avs_address == REG_LATCH);
	wire logic        wcfg_w = wr_w & (avs_address == REG_CFG)
		& avs_byteenable[0];
	wire logic rc_clr = ctl_w & avs_writedata[C_CLR];
	wire logic rc_on  = ctl_w & avs_writedata[C_ON];
	wire logic rc_off = ctl_w & avs_writedata[C_OFF];
	wire logic rc_aon = ctl_w & avs_writedata[C_AUX_ON];
	wire logic rc_aof = ctl_w & avs_writedata[C_AUX_OFF];

	// ****************************************
	// source gating
	// ****************************************
	logic [9:0] msk_vec;
	logic [9:0] lat_vec;
	always_comb begin
		msk_vec = '0;
		lat_vec = '0;
		msk_vec[A_OTP]    = mask_q[M_OTP];
		msk_vec[A_OTP_S]  = mask_q[M_OTP_S];
		msk_vec[A_FAN]    = mask_q[M_FAN];
		msk_vec[A_FAN_S]  = mask_q[M_FAN_S];
		msk_vec[A_FLD]    = mask_q[M_FLD];
		msk_vec[A_EXT_SD] = mask_q[M_EXT];
		lat_vec[A_AC_FAIL] = latch_q[L_ACF];
		lat_vec[A_OTP]     = latch_q[L_OTP];
		lat_vec[A_OTP_S]   = latch_q[L_OTP_S];
		lat_vec[A_FLD]     = latch_q[L_FLD];
	end

	wire logic [9:0] cond_w = alarm_src & ~msk_vec;
	wire logic [9:0] drop_w = AUTO_VEC & ~cond_w;
	wire logic [9:0] new_w  = cond_w & ~pend_q;
	wire logic [9:0] top_oh = pend_q & ~(pend_q - 10'h001);
	wire logic       clr_evt = enc_long | rc_clr;
	wire logic [9:0] clr_one = clr_evt ? top_oh : 10'h000;
	// set wins: a live cause re-arms in the clearing cycle
	// masking a source also drops a flag it left pending
	wire logic [9:0] pend_d = (pend_q & ~clr_one & ~drop_w & ~msk_vec)
		| cond_w;

	always_comb begin
		top_idx = '0;
		for (int i = ALARM_N - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				top_idx = 4'(i + 1);
			end
		end
	end

	// ****************************************
	// output control
	// ****************************************
	wire logic off_new = |(new_w & OFF_VEC);
	wire logic blocked = (|(pend_q & OFF_VEC)) | ff_q;
	wire logic trip_end = trip_q & ~(|(pend_q & OFF_VEC)) & ~off_new;
	wire logic on_req = (out_short & ~oset_q & ~out_en_q) | rc_on;
	wire logic off_req = (out_short & ~oset_q & out_en_q) | rc_off;
	wire logic on_ok = on_req & ~blocked;
	wire logic led_clr = (clr_evt | on_ok) & (pend_d == '0)
		& ~ff_q;
	wire logic led_set = (|new_w) | (boot_q & chk_fail);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			out_en_q <= 1'b0;
		end else if (off_new | ff_q) begin
			out_en_q <= 1'b0;
		end else if (boot_q) begin
			out_en_q <= nv_out_rst & nv_out_prev & ~chk_fail;
		end else if (trip_end) begin
			out_en_q <= pre_q & ~lhit_q;
		end else if (on_ok) begin
			out_en_q <= 1'b1;
		end else if (off_req) begin
			out_en_q <= 1'b0;
		end
	end

	// pre-alarm state and whether any latched source took part
	always_ff @(posedge core_clk) begin
		if (reset) begin
			trip_q <= 1'b0;
			pre_q  <= 1'b0;
			lhit_q <= 1'b0;
		end else if (off_new) begin
			trip_q <= 1'b1;
			pre_q  <= trip_q ? pre_q : (out_en_q | (boot_q & nv_out_rst
				& nv_out_prev));
			lhit_q <= (trip_q & lhit_q) | (|(new_w & lat_vec));
		end else if (trip_end) begin
			trip_q <= 1'b0;
			lhit_q <= 1'b0;
		end
	end

	// ****************************************
	// alarm state and indicator
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pend_q      <= '0;
			boot_q      <= 1'b1;
			ff_q        <= 1'b0;
			alarm_led_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			boot_q <= 1'b0;
			// sampled once; only reset removes it
			ff_q <= ff_q | (boot_q & chk_fail);
			if (led_set) begin
				alarm_led_q <= 1'b1;
			end else if (led_clr) begin
				alarm_led_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// settings, aux and display
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_q    <= '0;
			aux_en_q <= 1'b0;
			oset_q   <= 1'b0;
			aset_q   <= 1'b0;
		end else if (boot_q) begin
			cfg_q.out_rst <= nv_out_rst;
			cfg_q.aux_rst <= nv_aux_rst;
			aux_en_q      <= nv_aux_rst;
		end else begin
			oset_q <= oset_q ^ out_long;
			aset_q <= aset_q ^ aux_long;
			if (wcfg_w) begin
				cfg_q.out_rst <= avs_writedata[CFG_OUT];
				cfg_q.aux_rst <= avs_writedata[CFG_AUX];
			end else begin
				cfg_q.out_rst <= cfg_q.out_rst ^ (oset_q & out_short);
				cfg_q.aux_rst <= cfg_q.aux_rst ^ (aset_q & aux_short);
			end
			if (rc_aon | rc_aof) begin
				aux_en_q <= rc_aon;
			end else if (aux_short & ~aset_q) begin
				aux_en_q <= ~aux_en_q;
			end
		end
	end

	always_comb begin
		if (ff_q) begin
			disp_d = MSG_CHECKSUM_FAIL;
		end else if (oset_q) begin
			disp_d = cfg_q.out_rst ? MSG_OUTPUT_RESTORE_ON
				: MSG_OUTPUT_RESTORE_OF;
		end else if (aset_q) begin
			disp_d = cfg_q.aux_rst ? MSG_AUX_RESTORE_ON
				: MSG_AUX_RESTORE_OF;
		end else begin
			disp_d = top_idx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			disp_msg_q   <= MSG_NORMAL;
			disp_blink_q <= 1'b0;
		end else begin
			disp_msg_q   <= disp_d;
			disp_blink_q <= ff_q | ((|pend_q) & ~oset_q & ~aset_q);
		end
	end

	// ****************************************
	// register file and bus answer
	// ****************************************
	wire logic [31:0] state_w = {20'h0, top_idx, 3'h0, trip_q, ff_q,
		alarm_led_q, aux_en_q, out_en_q};
	wire logic [31:0] rd_mux =
		(avs_address == REG_MASK)  ? {23'h0, mask_q} :
		(avs_address == REG_LATCH) ? {24'h0, latch_q} :
		(avs_address == REG_CFG)   ? {30'h0, cfg_q.aux_rst, cfg_q.out_rst} :
		(avs_address == REG_COND)  ? {22'h0, cond_w} :
		(avs_address == REG_PEND)  ? {22'h0, pend_q} :
		(avs_address == REG_STATE) ? state_w : 32'h0000_0000;

	// two-cycle answer; unmapped reads give zero, writes vanish
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wait_q       <= 1'b1;
			avs_readdata <= '0;
			mask_q       <= MASK_RST;
			latch_q      <= LATCH_RST;
		end else begin
			wait_q <= ~(req_w & wait_q);
			if (avs_read & wait_q) begin
				avs_readdata <= rd_mux;
			end
			if (wmsk_w) begin
				mask_q <= (mask_q & ~mwm_w)
					| (avs_writedata[8:0] & mwm_w);
			end
			if (wlat_w) begin
				latch_q <= (latch_q & ~lwm_w) | (avs_writedata[7:0] & lwm_w);
			end
		end
	end

	// ****************************************
	// buttons
	// ****************************************
	apm_hold #(.N(OUT_HOLD)) u_out_hold (
		.core_clk (core_clk),
		.reset    (reset),
		.btn      (btn_out),
		.long_p   (out_long),
		.short_p  (out_short)
	);

	apm_hold #(.N(OUT_HOLD)) u_aux_hold (
		.core_clk (core_clk),
		.reset    (reset),
		.btn      (btn_aux),
		.long_p   (aux_long),
		.short_p  (aux_short)
	);

	apm_hold #(.N(ENC_HOLD)) u_enc_hold (
		.core_clk (core_clk),
		.reset    (reset),
		.btn      (btn_enc),
		.long_p   (enc_long),
		.short_p  ()
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	AST_BOOT_OUT: assert property (
		!reset && boot_q && !off_new |=> out_en_q ==
			($past(nv_out_rst) & $past(nv_out_prev) & !$past(chk_fail)))
		else $error("output not restored at boot");

	AST_BOOT_AUX: assert property (
		!reset && boot_q |=> aux_en_q == $past(nv_aux_rst))
		else $error("aux not restored at boot");

	AST_OFF_TRIP: assert property (
		off_new |=> !out_en_q ##1 (!out_en_q || !trip_q))
		else $error("output on after shutting alarm");

	AST_LED_SET: assert property (
		|new_w |=> alarm_led_q ##1
			(disp_blink_q || $past(oset_q) || $past(aset_q)))
		else $error("indicator not lit on trigger");

	AST_TOP_SHOWN: assert property (
		!ff_q && !oset_q && !aset_q |=> disp_msg_q == $past(top_idx))
		else $error("wrong alarm displayed");

	AST_RETRIG: assert property (
		|cond_w |=> (pend_q & $past(cond_w)) == $past(cond_w))
		else $error("live cause not pending");

	AST_CHK_TERM: assert property (
		ff_q |=> ff_q && !out_en_q)
		else $error("checksum alarm left");

	AST_ONE_CLR: assert property (
		clr_evt && !(|(top_oh & cond_w)) |=>
			(pend_q & $past(top_oh)) == '0 &&
			(pend_q & ~$past(top_oh) & ~AUTO_VEC) ==
			($past(pend_q) & ~$past(top_oh) & ~AUTO_VEC))
		else $error("clear touched other alarms");

	AST_LED_HOLD: assert property (
		alarm_led_q && !clr_evt && !on_ok |=> alarm_led_q)
		else $error("indicator dropped by itself");

	AST_MASKED: assert property (
		1'b1 |=> (pend_q & $past(msk_vec)) == '0)
		else $error("masked source pending");

	AST_BUS_ACK: assert property (
		req_w && wait_q |=> !wait_q ##1 wait_q)
		else $error("bus answer not one cycle");

endmodule

`default_nettype wire

// ===== include/apm_pkg.sv
// shared constants and types of the alarm priority mask core
// assumes a 50 MHz core clock and byte-addressed register words
package apm_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned OUT_HOLD_MS  = 1000;
	localparam int unsigned ENC_HOLD_MS  = 3000;
	localparam int unsigned OUT_HOLD_CYC = OUT_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned ENC_HOLD_CYC = ENC_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_W       = 28;

	// ****************************************
	// alarms, index is precedence minus one
	// ****************************************
	localparam int unsigned ALARM_N   = 10;
	localparam int unsigned A_AC_FAIL = 0;
	localparam int unsigned A_OTP     = 1;
	localparam int unsigned A_OTP_S   = 2;
	localparam int unsigned A_FAN     = 3;
	localparam int unsigned A_FAN_S   = 4;
	localparam int unsigned A_FLD     = 8;
	localparam int unsigned A_EXT_SD  = 9;
	// self-clearing sources: ac, otp, fans, interlock, ext shutdown
	localparam logic [9:0] AUTO_VEC = 10'h23F;
	// every source but the two fans shuts the output
	localparam logic [9:0] OFF_VEC  = 10'h3E7;

	// ****************************************
	// mask and latch fields (weight = 2**pos)
	// ****************************************
	localparam int unsigned M_OTP   = 1;
	localparam int unsigned M_OTP_S = 2;
	localparam int unsigned M_FAN   = 3;
	localparam int unsigned M_FAN_S = 4;
	localparam int unsigned M_FLD   = 7;
	localparam int unsigned M_EXT   = 8;
	localparam int unsigned L_ACF   = 0;
	localparam int unsigned L_OTP   = 1;
	localparam int unsigned L_OTP_S = 2;
	localparam int unsigned L_FLD   = 7;
	localparam logic [8:0] MASK_WM   = 9'h19E;
	localparam logic [7:0] LATCH_WM  = 8'h87;
	localparam logic [8:0] MASK_RST  = 9'h000;
	localparam logic [7:0] LATCH_RST = 8'h00;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [4:0] REG_CTRL  = 5'h00;
	localparam logic [4:0] REG_MASK  = 5'h04;
	localparam logic [4:0] REG_LATCH = 5'h08;
	localparam logic [4:0] REG_CFG   = 5'h0C;
	localparam logic [4:0] REG_COND  = 5'h10;
	localparam logic [4:0] REG_PEND  = 5'h14;
	localparam logic [4:0] REG_STATE = 5'h18;
	localparam int unsigned C_CLR     = 0;
	localparam int unsigned C_ON      = 1;
	localparam int unsigned C_OFF     = 2;
	localparam int unsigned C_AUX_ON  = 3;
	localparam int unsigned C_AUX_OFF = 4;
	localparam int unsigned CFG_OUT   = 0;
	localparam int unsigned CFG_AUX   = 1;
	localparam int unsigned ST_OUT    = 0;
	localparam int unsigned ST_AUX    = 1;
	localparam int unsigned ST_LED    = 2;
	localparam int unsigned ST_CHK    = 3;
	localparam int unsigned ST_TRIP   = 4;
	localparam int unsigned ST_TOP    = 8;

	// ****************************************
	// display codes, 1..10 show alarm index+1
	// ****************************************
	localparam logic [3:0] MSG_NORMAL            = 4'h0;
	localparam logic [3:0] MSG_CHECKSUM_FAIL     = 4'hB;
	localparam logic [3:0] MSG_OUTPUT_RESTORE_ON = 4'hC;
	localparam logic [3:0] MSG_OUTPUT_RESTORE_OF = 4'hD;
	localparam logic [3:0] MSG_AUX_RESTORE_ON    = 4'hE;
	localparam logic [3:0] MSG_AUX_RESTORE_OF    = 4'hF;

	typedef struct packed {
		logic aux_rst;
		logic out_rst;
	} apm_cfg_t;

endpackage

// ===== dv/apm_panel_model.sv
// front panel buttons and remote host model of the alarm core
// assumes the core answers each bus transfer through waitrequest
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// panel and remote host
// ****************************************
module apm_panel_model (
	input  wire logic        core_clk,
	output logic [4:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic             btn_out,
	output logic             btn_aux,
	output logic             btn_enc
);
	initial begin
		avs_address    = 5'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
		btn_out        = 1'b0;
		btn_aux        = 1'b0;
		btn_enc        = 1'b0;
	end

	// request held until waitrequest is sampled low, no cycle assumed
	task automatic xfer(input logic wr, input logic [4:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write     <= 1'b0;
		avs_read      <= 1'b0;
		// stale data would hide a slave that samples late
		avs_writedata <= ~wd;
	endtask

	// hold one button for n cycles: 0 output, 1 aux, 2 encoder
	task automatic hold(input int b, input int n);
		@(posedge core_clk);
		if (b == 0) btn_out <= 1'b1;
		if (b == 1) btn_aux <= 1'b1;
		if (b == 2) btn_enc <= 1'b1;
		repeat (n) @(posedge core_clk);
		btn_out <= 1'b0;
		btn_aux <= 1'b0;
		btn_enc <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== dv/alarm_priority_mask_control_test.sv
// self-checking bench of the alarm core with panel model
// assumes hold counts shortened to 8 and 16 cycles
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench top
// ****************************************
module alarm_priority_mask_control_test;
	import apm_pkg::*;
	typedef struct packed {
		logic [9:0] src;
		logic [3:0] disp;
		logic       out;
	} apm_row_t;
	logic core_clk, reset, chk_fail, nv_out_prev, nv_out_rst, nv_aux_rst;
	logic [9:0]  alarm_src;
	logic [4:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0]  avs_byteenable, disp_msg_q;
	logic btn_out, btn_aux, btn_enc, out_en_q, aux_en_q, alarm_led_q;
	logic disp_blink_q, out_rst, aux_rst;
	int   n_fail, n_checks;
	apm_row_t rows [10];

	apm_core #(.OUT_HOLD(8), .ENC_HOLD(16)) i_apm_core (.core_clk(core_clk),
		.reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .alarm_src(alarm_src),
		.chk_fail(chk_fail), .nv_out_prev(nv_out_prev),
		.nv_out_rst(nv_out_rst), .nv_aux_rst(nv_aux_rst), .btn_out(btn_out),
		.btn_aux(btn_aux), .btn_enc(btn_enc), .out_en_q(out_en_q),
		.aux_en_q(aux_en_q), .alarm_led_q(alarm_led_q),
		.disp_msg_q(disp_msg_q), .disp_blink_q(disp_blink_q),
		.out_rst(out_rst), .aux_rst(aux_rst));
	apm_panel_model i_apm_panel_model (.core_clk(core_clk),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .btn_out(btn_out),
		.btn_aux(btn_aux), .btn_enc(btn_enc));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		give_verdict();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		i_apm_panel_model.xfer(1'b1, a, d, rd);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		i_apm_panel_model.xfer(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic src(input logic [9:0] s);
		@(posedge core_clk);
		alarm_src <= s;
	endtask

	initial begin
		reset = 1'b1;
		alarm_src = 10'h000;
		chk_fail = 1'b0;
		nv_out_prev = 1'b1;
		nv_out_rst = 1'b1;
		nv_aux_rst = 1'b1;
		n_fail = 0;
		n_checks = 0;
		for (int i = 0; i < 10; i++) begin
			rows[i] = '{10'h001 << i, 4'(i + 1), (i == 3 || i == 4)};
		end
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		cyc(3);
		chk(out_en_q, 1'b1);
		chk(aux_en_q, 1'b1);
		chk(out_rst, 1'b1);
		chk(aux_rst, 1'b1);
		$display("boot restore done");
		i_apm_panel_model.hold(0, 10);
		cyc(3);
		chk(disp_msg_q, MSG_OUTPUT_RESTORE_ON);
		i_apm_panel_model.hold(0, 2);
		cyc(4);
		chk(out_rst, 1'b0);
		chk(disp_msg_q, MSG_OUTPUT_RESTORE_OF);
		chk(out_en_q, 1'b1);
		i_apm_panel_model.hold(0, 10);
		i_apm_panel_model.hold(1, 2);
		cyc(4);
		chk(aux_en_q, 1'b0);
		i_apm_panel_model.hold(1, 10);
		cyc(3);
		chk(disp_msg_q, MSG_AUX_RESTORE_ON);
		i_apm_panel_model.hold(1, 2);
		cyc(4);
		chk(aux_rst, 1'b0);
		chk(disp_msg_q, MSG_AUX_RESTORE_OF);
		chk(aux_en_q, 1'b0);
		i_apm_panel_model.hold(1, 10);
		wr(REG_CFG, 32'h3);
		rdc(REG_CFG, 32'h3);
		chk(out_rst, 1'b1);
		chk(aux_rst, 1'b1);
		wr(REG_CTRL, 32'h4);
		cyc(1);
		chk(out_en_q, 1'b0);
		wr(REG_CTRL, 32'h2);
		wr(REG_CTRL, 32'h10);
		cyc(1);
		chk(aux_en_q, 1'b0);
		wr(REG_CTRL, 32'h18);
		cyc(1);
		chk(aux_en_q, 1'b1);
		chk(out_en_q, 1'b1);
		$display("restore setting done");
		for (int i = 0; i < 10; i++) begin
			src(rows[i].src);
			cyc(3);
			chk(disp_msg_q, rows[i].disp);
			chk(disp_blink_q, 1'b1);
			chk(alarm_led_q, 1'b1);
			chk(out_en_q, rows[i].out);
			rdc(REG_COND, {22'h0, rows[i].src});
			src(10'h000);
			wr(REG_CTRL, 32'h1);
			wr(REG_CTRL, 32'h2);
			cyc(3);
			chk(alarm_led_q, 1'b0);
		end
		$display("alarm table done");
		src(10'h0C0);
		cyc(3);
		chk(disp_msg_q, 4'h7);
		rdc(REG_PEND, 32'h0C0);
		rdc(REG_STATE, 32'h716);
		src(10'h080);
		i_apm_panel_model.hold(2, 20);
		cyc(3);
		chk(disp_msg_q, 4'h8);
		wr(REG_CTRL, 32'h1);
		cyc(3);
		chk(disp_msg_q, 4'h8);
		src(10'h000);
		wr(REG_CTRL, 32'h1);
		cyc(3);
		chk(disp_msg_q, MSG_NORMAL);
		chk(alarm_led_q, 1'b0);
		wr(REG_CTRL, 32'h2);
		$display("clear order done");
		wr(REG_LATCH, 32'h2);
		src(10'h002);
		cyc(3);
		src(10'h000);
		cyc(4);
		chk(disp_msg_q, MSG_NORMAL);
		chk(alarm_led_q, 1'b1);
		chk(out_en_q, 1'b0);
		i_apm_panel_model.hold(0, 2);
		cyc(4);
		chk(out_en_q, 1'b1);
		chk(alarm_led_q, 1'b0);
		wr(REG_LATCH, 32'h0);
		$display("auto clear done");
		wr(REG_MASK, 32'hFFFF);
		rdc(REG_MASK, 32'h19E);
		src(10'h33E);
		cyc(3);
		chk(disp_msg_q, 4'h6);
		rdc(REG_COND, 32'h020);
		src(10'h31E);
		wr(REG_CTRL, 32'h1);
		cyc(3);
		chk(alarm_led_q, 1'b0);
		rdc(REG_MASK, 32'h19E);
		rdc(5'h1C, 32'h0);
		src(10'h000);
		wr(REG_MASK, 32'h0);
		$display("mask done");
		@(posedge core_clk);
		reset <= 1'b1;
		nv_out_rst <= 1'b0;
		chk_fail <= 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		cyc(3);
		chk(out_en_q, 1'b0);
		chk(disp_msg_q, MSG_CHECKSUM_FAIL);
		@(posedge core_clk);
		chk_fail <= 1'b0;
		wr(REG_CTRL, 32'h1);
		cyc(3);
		chk(disp_msg_q, MSG_CHECKSUM_FAIL);
		$display("power cycle done");
		give_verdict();
	end
endmodule

`default_nettype wire
